// file: inc/ures_pkg.sv
// shared constants for the usb receive endpoint status block
package ures_pkg;
    // ****************************************
    // sizes
    // ****************************************
    localparam int URES_EP_NUM = 4;
    localparam int URES_EP_W   = 2;
    localparam int URES_ADDR_W = 12;
    localparam int URES_IRQ_W  = 2;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] URES_IDX_EP_SEL    = 8'he0;
    localparam logic [7:0] URES_IDX_RX_STATUS = 8'he2;
    localparam logic [7:0] URES_IDX_IRQ_STAT  = 8'he4;
    localparam logic [7:0] URES_IDX_IRQ_MASK  = 8'he5;

    // ****************************************
    // rx_endpoint_status fields and reset
    // ****************************************
    localparam int         URES_BIT_TOGGLE = 7;
    localparam int         URES_BIT_ERR    = 1;
    localparam int         URES_BIT_ACK    = 0;
    localparam logic [7:0] URES_RST_STATUS = 8'h00;

    // ****************************************
    // interrupt event bits and resets
    // ****************************************
    localparam int                    URES_IRQ_ERR   = 0;
    localparam int                    URES_IRQ_ACK   = 1;
    localparam logic [URES_IRQ_W-1:0] URES_RST_MASK  = 2'h0;
    localparam logic [URES_IRQ_W-1:0] URES_RST_ISTAT = 2'h0;
endpackage

// file: inc/ures_ev_if.sv
// result of one finished reception, passed from evaluator to status logic
`timescale 1ns/1ps
interface ures_ev_if
    import ures_pkg::*;
();
    logic                 done;
    logic [URES_EP_W-1:0] ep;
    logic                 err;
    logic                 tog_next;

    modport src
    (
        output done,
        output ep,
        output err,
        output tog_next
    );
    modport dst
    (
        input done,
        input ep,
        input err,
        input tog_next
    );
endinterface

// file: rtl/ures_rx_eval.sv
// judges a finished reception: error, handshake, fifo commit, next toggle
`timescale 1ns/1ps
module ures_rx_eval
    import ures_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 resetn_in,
    input  wire logic                 ce_in,
    // reception end from the serial engine
    input  wire logic                 rx_done_in,
    input  wire logic [URES_EP_W-1:0] rx_ep_in,
    input  wire logic                 rx_setup_in,
    input  wire logic                 rx_pid_toggle_in,
    input  wire logic                 rx_crc_err_in,
    input  wire logic                 rx_stuff_err_in,
    input  wire logic                 rx_fifo_ovr_in,
    input  wire logic                 rx_fifo_unr_in,
    input  wire logic                 exp_toggle_in,
    // results
    output logic                      hs_ack_out,
    output logic                      fifo_commit_out,
    ures_ev_if.src                    ev
);
    // ****************************************
    // decode
    // ****************************************
    // any of four faults
    wire any_err = rx_crc_err_in | rx_stuff_err_in | rx_fifo_ovr_in | rx_fifo_unr_in;
    wire tog_ok  = rx_setup_in | (rx_pid_toggle_in == exp_toggle_in);
    wire tog_nx  = rx_setup_in ? 1'b1 : (tog_ok ? ~exp_toggle_in : exp_toggle_in);

    // ****************************************
    // registered outcome
    // ****************************************
    // outcome flops, one cycle after rx_done_in
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ev.done         <= 1'b0;
            ev.ep           <= '0;
            ev.err          <= 1'b0;
            ev.tog_next     <= 1'b0;
            hs_ack_out      <= 1'b0;
            fifo_commit_out <= 1'b0;
        end
        else if (ce_in)
        begin
            ev.done         <= rx_done_in;
            ev.ep           <= rx_ep_in;
            ev.err          <= any_err;
            ev.tog_next     <= tog_nx;
            hs_ack_out      <= rx_done_in & ~any_err;
            fifo_commit_out <= rx_done_in;
        end
    end
endmodule

// file: rtl/ures_irq.sv
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
module ures_irq
    import ures_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  resetn_in,
    input  wire logic                  ce_in,
    // events and software access
    input  wire logic [URES_IRQ_W-1:0] set_in,
    input  wire logic                  stat_wr_in,
    input  wire logic                  mask_wr_in,
    input  wire logic [URES_IRQ_W-1:0] wdata_in,
    // state
    output logic      [URES_IRQ_W-1:0] stat_out,
    output logic      [URES_IRQ_W-1:0] mask_out,
    output logic                       irq_out
);
    // write one to clear, a set in the same cycle wins
    wire [URES_IRQ_W-1:0] clr = stat_wr_in ? wdata_in : '0;

    // status and mask flops
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stat_out <= URES_RST_ISTAT;
            mask_out <= URES_RST_MASK;
        end
        else if (ce_in)
        begin
            stat_out <= (stat_out & ~clr) | set_in;
            if (mask_wr_in)
            begin
                mask_out <= wdata_in;
            end
        end
    end

    // level output, high while an unmasked bit is set
    assign irq_out = |(stat_out & mask_out);
endmodule

// file: rtl/ures_top.sv
// per-endpoint receive status with apb register access and interrupt
`timescale 1ns/1ps
module ures_top
    import ures_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   core_clk_in,
    input  wire logic                   resetn_in,
    input  wire logic                   ce_in,
    // apb slave
    input  wire logic [URES_ADDR_W-1:0] paddr_in,
    input  wire logic                   psel_in,
    input  wire logic                   penable_in,
    input  wire logic                   pwrite_in,
    input  wire logic [31:0]            pwdata_in,
    output logic      [31:0]            prdata_out,
    output logic                        pready_out,
    output logic                        pslverr_out,
    // serial engine reception end
    input  wire logic                   rx_done_in,
    input  wire logic [URES_EP_W-1:0]   rx_ep_in,
    input  wire logic                   rx_setup_in,
    input  wire logic                   rx_pid_toggle_in,
    input  wire logic                   rx_crc_err_in,
    input  wire logic                   rx_stuff_err_in,
    input  wire logic                   rx_fifo_ovr_in,
    input  wire logic                   rx_fifo_unr_in,
    // serial engine answers
    output logic                        hs_ack_out,
    output logic                        fifo_commit_out,
    // interrupt
    output logic                        irq_out
);
    // ****************************************
    // state
    // ****************************************
    logic [URES_EP_W-1:0]   ep_sel_q;
    logic [URES_EP_NUM-1:0] tog_q;
    logic [URES_EP_NUM-1:0] err_q;
    logic [URES_EP_NUM-1:0] ack_q;
    logic [31:0]            rdata_q;
    logic                   slverr_q;
    logic [URES_IRQ_W-1:0]  istat;
    logic [URES_IRQ_W-1:0]  imask;
    logic [URES_IRQ_W-1:0]  iset;

    ures_ev_if ev ();

    // ****************************************
    // apb decode
    // ****************************************
    // register word index and strobes
    wire [URES_ADDR_W-3:0] idx    = paddr_in[URES_ADDR_W-1:2];
    wire                   setup  = psel_in & ~penable_in & ce_in;
    wire                   access = psel_in & penable_in & ce_in;
    wire                   hit_ep = idx == {2'b00, URES_IDX_EP_SEL};
    wire                   hit_st = idx == {2'b00, URES_IDX_RX_STATUS};
    wire                   hit_is = idx == {2'b00, URES_IDX_IRQ_STAT};
    wire                   hit_im = idx == {2'b00, URES_IDX_IRQ_MASK};
    wire                   mapped = hit_ep | hit_st | hit_is | hit_im;
    wire                   wr     = access & pwrite_in;
    wire                   wr_ep  = wr & hit_ep;
    wire                   wr_st  = wr & hit_st;
    wire                   wr_is  = wr & hit_is;
    wire                   wr_im  = wr & hit_im;

    // selected endpoint status byte
    wire [7:0] st_byte = {tog_q[ep_sel_q], 5'b0_0000, err_q[ep_sel_q], ack_q[ep_sel_q]};

    // read mux, unmapped reads zero
    wire [31:0] rmux = hit_ep ? {30'h0000_0000, ep_sel_q} :
                       hit_st ? {24'h00_0000, st_byte} :
                       hit_is ? {30'h0000_0000, istat} :
                       hit_im ? {30'h0000_0000, imask} : 32'h0000_0000;

    // zero wait: answer in first access cycle
    assign pready_out  = psel_in & penable_in & ce_in;
    assign prdata_out  = rdata_q;
    assign pslverr_out = pready_out & slverr_q;

    // read data and error caught in setup cycle
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end
        else if (setup)
        begin
            rdata_q  <= pwrite_in ? 32'h0000_0000 : rmux;
            slverr_q <= ~mapped;
        end
    end

    // endpoint select register
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ep_sel_q <= '0;
        end
        else if (wr_ep)
        begin
            ep_sel_q <= pwdata_in[URES_EP_W-1:0];
        end
    end

    // ****************************************
    // reception evaluation
    // ****************************************
    wire exp_tog = tog_q[rx_ep_in];

    ures_rx_eval ures_rx_eval_i
    (
        .clk_in           (core_clk_in),
        .resetn_in        (resetn_in),
        .ce_in            (ce_in),
        .rx_done_in       (rx_done_in),
        .rx_ep_in         (rx_ep_in),
        .rx_setup_in      (rx_setup_in),
        .rx_pid_toggle_in (rx_pid_toggle_in),
        .rx_crc_err_in    (rx_crc_err_in),
        .rx_stuff_err_in  (rx_stuff_err_in),
        .rx_fifo_ovr_in   (rx_fifo_ovr_in),
        .rx_fifo_unr_in   (rx_fifo_unr_in),
        .exp_toggle_in    (exp_tog),
        .hs_ack_out       (hs_ack_out),
        .fifo_commit_out  (fifo_commit_out),
        .ev               (ev.src)
    );

    // ****************************************
    // per-endpoint status flags
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < URES_EP_NUM; g++)
        begin : g_ep
            wire hit_ev = ev.done & (ev.ep == URES_EP_W'(g));
            wire hit_fw = wr_st & (ep_sel_q == URES_EP_W'(g));

            // hardware update wins over firmware write
            always_ff @(posedge core_clk_in or negedge resetn_in)
            begin
                if (!resetn_in)
                begin
                    tog_q[g] <= URES_RST_STATUS[URES_BIT_TOGGLE];
                    err_q[g] <= URES_RST_STATUS[URES_BIT_ERR];
                    ack_q[g] <= URES_RST_STATUS[URES_BIT_ACK];
                end
                else if (ce_in)
                begin
                    if (hit_ev)
                    begin
                        err_q[g] <= ev.err;
                        ack_q[g] <= ~ev.err;
                        if (!ev.err)
                        begin
                            tog_q[g] <= ev.tog_next;
                        end
                    end
                    else if (hit_fw)
                    begin
                        tog_q[g] <= pwdata_in[URES_BIT_TOGGLE];
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // interrupt
    // ****************************************
    // events: error and acked reception
    assign iset[URES_IRQ_ERR] = ev.done & ev.err;
    assign iset[URES_IRQ_ACK] = ev.done & ~ev.err;

    ures_irq ures_irq_i
    (
        .clk_in     (core_clk_in),
        .resetn_in  (resetn_in),
        .ce_in      (ce_in),
        .set_in     (iset),
        .stat_wr_in (wr_is),
        .mask_wr_in (wr_im),
        .wdata_in   (pwdata_in[URES_IRQ_W-1:0]),
        .stat_out   (istat),
        .mask_out   (imask),
        .irq_out    (irq_out)
    );

    // ****************************************
    // assertions
    // ****************************************
    wire any_fault = rx_crc_err_in | rx_stuff_err_in | rx_fifo_ovr_in | rx_fifo_unr_in;

    property p_err_flag;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ev.done && ev.err && ce_in |=> err_q[$past(ev.ep)] && !ack_q[$past(ev.ep)];
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error flag not set");

    property p_commit;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in |=> fifo_commit_out;
    endproperty
    a_commit: assert property (p_commit) else $error("data not committed");

    property p_no_hs;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in && any_fault |=> !hs_ack_out;
    endproperty
    a_no_hs: assert property (p_no_hs) else $error("handshake after error");

    property p_fault_kind;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in ##1 ce_in |=> err_q[$past(rx_ep_in, 2)] == $past(any_fault, 2);
    endproperty
    a_fault_kind: assert property (p_fault_kind) else $error("wrong error class");

    property p_toggle;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in && !any_fault && !rx_setup_in
            && (rx_pid_toggle_in == exp_tog) ##1 ce_in
        |=> tog_q[$past(rx_ep_in, 2)] != $past(exp_tog, 2);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle did not advance");

    property p_excl;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (err_q & ack_q) == '0;
    endproperty
    a_excl: assert property (p_excl) else $error("error and ack both set");

    property p_ack_flag;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ev.done && !ev.err && ce_in |=> ack_q[$past(ev.ep)] && !err_q[$past(ev.ep)];
    endproperty
    a_ack_flag: assert property (p_ack_flag) else $error("acked flag not set");

    property p_hs_good;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in && !any_fault |=> hs_ack_out;
    endproperty
    a_hs_good: assert property (p_hs_good) else $error("no handshake for clean data");

    property p_pulse_only;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !rx_done_in && ce_in |=> !fifo_commit_out && !hs_ack_out;
    endproperty
    a_pulse_only: assert property (p_pulse_only) else $error("pulse without reception");

    property p_err_tog;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in && any_fault ##1 ce_in
        |=> tog_q[$past(rx_ep_in, 2)] == $past(exp_tog, 2);
    endproperty
    a_err_tog: assert property (p_err_tog) else $error("toggle moved on error");

    property p_setup_tog;
        @(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && ce_in && !any_fault && rx_setup_in ##1 ce_in
        |=> tog_q[$past(rx_ep_in, 2)];
    endproperty
    a_setup_tog: assert property (p_setup_tog) else $error("toggle not one after setup");

    property p_irq_err;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ev.done && ev.err && ce_in |=> istat[URES_IRQ_ERR];
    endproperty
    a_irq_err: assert property (p_irq_err) else $error("error event not latched");

    property p_irq_ack;
        @(posedge core_clk_in) disable iff (!resetn_in)
        ev.done && !ev.err && ce_in |=> istat[URES_IRQ_ACK];
    endproperty
    a_irq_ack: assert property (p_irq_ack) else $error("acked event not latched");

    // main scenarios
    c_err_rx: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        ev.done && ev.err);
    c_ok_rx: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        hs_ack_out);
    c_irq: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        irq_out);
    c_setup_rx: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        rx_done_in && rx_setup_in && ce_in);
    c_fw_toggle: cover property (@(posedge core_clk_in) disable iff (!resetn_in)
        wr_st);
endmodule

// file: test/ures_host_model.sv
// behavioural serial engine side: produces reception-end pulses
`timescale 1ns/1ps
module ures_host_model
(
    // clock and observed answers
    input  wire logic       clk_in,
    input  wire logic       hs_ack_in,
    input  wire logic       commit_in,
    // reception end towards the block
    output logic            rx_done_out,
    output logic      [1:0] rx_ep_out,
    output logic            rx_setup_out,
    output logic            rx_pid_out,
    output logic      [3:0] rx_flt_out
);
    // ****************************************
    // idle state
    // ****************************************
    initial
    begin
        rx_done_out  = 1'b0;
        rx_ep_out    = 2'h0;
        rx_setup_out = 1'b0;
        rx_pid_out   = 1'b0;
        rx_flt_out   = 4'h0;
    end

    // ****************************************
    // one reception: pulse, then inverted qualifiers so stale values never match
    // ****************************************
    task automatic receive(input logic [1:0] ep, input logic setup, input logic pid,
                           input logic [3:0] flt, output logic ack, output logic commit);
        @(posedge clk_in);
        rx_done_out  <= 1'b1;
        rx_ep_out    <= ep;
        rx_setup_out <= setup;
        rx_pid_out   <= pid;
        rx_flt_out   <= flt;
        @(posedge clk_in);
        rx_done_out  <= 1'b0;
        rx_ep_out    <= ~ep;
        rx_setup_out <= ~setup;
        rx_pid_out   <= ~pid;
        rx_flt_out   <= ~flt;
        #1;
        ack    = hs_ack_in;
        commit = commit_in;
    endtask
endmodule

// file: test/usb_receive_endpoint_status_tb.sv
// self-checking bench for the receive endpoint status block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module usb_receive_endpoint_status_tb;
    import ures_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [11:0] A_SEL  = {2'b00, URES_IDX_EP_SEL, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, URES_IDX_RX_STATUS, 2'b00};
    localparam logic [11:0] A_IST  = {2'b00, URES_IDX_IRQ_STAT, 2'b00};
    localparam logic [11:0] A_MSK  = {2'b00, URES_IDX_IRQ_MASK, 2'b00};
    logic        clk, resetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        rx_done, rx_setup, rx_pid, hs_ack, commit, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  rx_ep;
    logic [3:0]  flt;
    logic        er, a, c;
    int          n_mismatch, checks, cyc;

    // ****************************************
    // clock, design and partner
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ures_top ures_top_i (.core_clk_in(clk), .resetn_in(resetn), .ce_in(ce),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .rx_done_in(rx_done), .rx_ep_in(rx_ep), .rx_setup_in(rx_setup),
        .rx_pid_toggle_in(rx_pid), .rx_crc_err_in(flt[0]), .rx_stuff_err_in(flt[1]),
        .rx_fifo_ovr_in(flt[2]), .rx_fifo_unr_in(flt[3]), .hs_ack_out(hs_ack),
        .fifo_commit_out(commit), .irq_out(irq));
    ures_host_model ures_host_model_i (.clk_in(clk), .hs_ack_in(hs_ack), .commit_in(commit),
        .rx_done_out(rx_done), .rx_ep_out(rx_ep), .rx_setup_out(rx_setup),
        .rx_pid_out(rx_pid), .rx_flt_out(flt));

    // ****************************************
    // apb master
    // ****************************************
    task automatic apb(input logic [11:0] ad, input logic wr, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= ad;
        pwrite  <= wr;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // wait for the answer; pready ends this wait, the bench timeout ends it if pready never comes
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] st(input logic t, input logic e, input logic k);
        st = {24'h00_0000, t, 5'h00, e, k};
    endfunction

    // ****************************************
    // verdict and timeout
    // ****************************************
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        n_mismatch = 0;
        checks     = 0;
        cyc        = 0;
        resetn     = 1'b0;
        ce         = 1'b1;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 12'h000;
        pwdata     = 32'h0000_0000;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        // reset values and unmapped place
        apb(A_STAT, 1'b0, 32'h0000_0000);
        `CHK("status reset", st(0, 0, 0), rd)
        apb(A_IST, 1'b0, 32'h0000_0000);
        `CHK("irq status reset", 32'h0000_0000, rd)
        apb(A_MSK, 1'b0, 32'h0000_0000);
        `CHK("irq mask reset", 32'h0000_0000, rd)
        apb(12'h004, 1'b0, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0000_0000, rd)
        // endpoint 1: toggle set at init, read-only flags ignore writes
        apb(A_SEL, 1'b1, 32'h0000_0001);
        apb(A_STAT, 1'b1, 32'h0000_0083);
        apb(A_STAT, 1'b0, 32'h0000_0000);
        `CHK("status rw", st(1, 0, 0), rd)
        // every fault kind; first one with interrupt masked
        for (int k = 0; k < 4; k++)
        begin
            ures_host_model_i.receive(2'd1, 1'b0, 1'b1, 4'h1 << k, a, c);
            `CHK("commit on error", 1'b1, c)
            `CHK("no handshake", 1'b0, a)
            apb(A_STAT, 1'b0, 32'h0000_0000);
            `CHK("error flags", st(1, 1, 0), rd)
            apb(A_IST, 1'b0, 32'h0000_0000);
            `CHK("irq err event", 32'h0000_0001, rd)
            `CHK("irq level", (k != 0), irq)
            apb(A_IST, 1'b1, 32'h0000_0003);
            `CHK("irq cleared", 1'b0, irq)
            apb(A_MSK, 1'b1, 32'h0000_0003);
        end
        // endpoint 2: setup, matching data1, then mismatch
        apb(A_SEL, 1'b1, 32'h0000_0002);
        for (int k = 0; k < 3; k++)
        begin
            ures_host_model_i.receive(2'd2, (k == 0), (k != 0), 4'h0, a, c);
            `CHK("ack sent", 1'b1, a)
            `CHK("commit good", 1'b1, c)
            apb(A_STAT, 1'b0, 32'h0000_0000);
            `CHK("ack flags toggle", st((k == 0), 0, 1), rd)
            `CHK("irq ack level", 1'b1, irq)
            apb(A_IST, 1'b1, 32'h0000_0003);
        end
        // endpoint 3: error then good replaces the flags, both events stick
        ures_host_model_i.receive(2'd3, 1'b0, 1'b0, 4'h5, a, c);
        ures_host_model_i.receive(2'd3, 1'b1, 1'b0, 4'h0, a, c);
        apb(A_SEL, 1'b1, 32'h0000_0003);
        apb(A_STAT, 1'b0, 32'h0000_0000);
        `CHK("flags replaced", st(1, 0, 1), rd)
        apb(A_IST, 1'b0, 32'h0000_0000);
        `CHK("both events", 32'h0000_0003, rd)
        // clock enable low: a reception on endpoint 1 is not taken
        ce <= 1'b0;
        ures_host_model_i.receive(2'd1, 1'b0, 1'b0, 4'h0, a, c);
        `CHK("frozen commit", 1'b0, c)
        `CHK("frozen handshake", 1'b0, a)
        ce <= 1'b1;
        // endpoint 1 untouched by others
        apb(A_SEL, 1'b1, 32'h0000_0001);
        apb(A_STAT, 1'b0, 32'h0000_0000);
        `CHK("ep isolation", st(1, 1, 0), rd)
        finish_test();
    end
endmodule
